// >>> pkg/bbop_pkg.sv
// Constants, types and helpers shared by the byte and bit operation execute unit
// Notes on behaviour
// - and_acc_into_reg ANDs accumulator with register 0..127, writes target, updates only zero flag.
// - Target select 0 writes accumulator, 1 writes back into the addressed register.
// - add_acc_to_reg adds accumulator and register, writes target, updates carry, nibble, zero.
// - arith_shift_right shifts register right, keeps bit 7, bit 0 goes to carry, updates zero.
// - add_with_carry_to_reg adds accumulator, register and carry; updates carry, nibble and zero.
// - clear_bit_in_reg clears one selected bit 0..7, keeps others, touches no flag.
// - test_bit_skip_if_zero with bit clear discards next instruction as a no-op, no flags.
// - Indirect port access with pointer top bit set costs one extra instruction cycle.
package bbop_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int PTR_W = 16;
    localparam int NUM_REGS = 128;
    localparam int BIT_W = 3;
    // Field positions
    localparam int MSB_POS = 7;
    localparam int NIBBLE_POS = 4;
    localparam int PTR_MSB_POS = 15;
    // Addresses of the two indirect access ports in the register space
    localparam logic [6:0] IND0_ADDR = 7'h00;
    localparam logic [6:0] IND1_ADDR = 7'h01;
    // Result target select encodings
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_REG = 1'b1;
    // Reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic FLAG_RST = 1'b0;

    typedef enum logic [2:0] {
        OP_NOP,
        OP_AND,
        OP_ADD,
        OP_ASR,
        OP_ADDC,
        OP_BCLR,
        OP_BTSZ
    } op_t;

    // One-hot mask for a bit position
    function automatic logic [7:0] bit_mask(input logic [2:0] pos);
        bit_mask = 8'h01 << pos;
    endfunction

    // Zero detect on an 8-bit result
    function automatic logic is_zero(input logic [7:0] value);
        is_zero = (value == 8'h00);
    endfunction
endpackage

// >>> hw/bbop_alu.sv
// Combinational result and flag generation for the byte and bit operations
module bbop_alu (
    input wire bbop_pkg::op_t i_op,
    input wire logic [7:0] i_acc,
    input wire logic [7:0] i_opnd,
    input wire logic i_carry,
    input wire logic [2:0] i_bit,
    output logic [7:0] o_result,
    output logic o_carry,
    output logic o_nibble,
    output logic o_zero,
    output logic o_upd_carry,
    output logic o_upd_nibble,
    output logic o_upd_zero,
    output logic o_write,
    output logic o_skip
);
    logic [8:0] sum;
    logic [4:0] nib_sum;
    logic cin;

    // Carry in only joins the sum for the add-with-carry form
    always_comb begin
        cin = (i_op == bbop_pkg::OP_ADDC) ? i_carry : 1'b0;
        sum = {1'b0, i_acc} + {1'b0, i_opnd} + {8'h00, cin};
        nib_sum = {1'b0, i_acc[3:0]} + {1'b0, i_opnd[3:0]} + {4'h0, cin};
    end

    // Result, flag values and which flags the operation may touch
    always_comb begin
        o_result = i_opnd;
        o_carry = sum[8];
        o_nibble = nib_sum[bbop_pkg::NIBBLE_POS];
        o_upd_carry = 1'b0;
        o_upd_nibble = 1'b0;
        o_upd_zero = 1'b0;
        o_write = 1'b0;
        o_skip = 1'b0;
        case (i_op)
            bbop_pkg::OP_AND: begin
                o_result = i_acc & i_opnd;
                o_upd_zero = 1'b1;
                o_write = 1'b1;
            end
            bbop_pkg::OP_ADD, bbop_pkg::OP_ADDC: begin
                o_result = sum[7:0];
                o_upd_carry = 1'b1;
                o_upd_nibble = 1'b1;
                o_upd_zero = 1'b1;
                o_write = 1'b1;
            end
            bbop_pkg::OP_ASR: begin
                o_result = {i_opnd[bbop_pkg::MSB_POS], i_opnd[7:1]};
                o_carry = i_opnd[0];
                o_upd_carry = 1'b1;
                o_upd_zero = 1'b1;
                o_write = 1'b1;
            end
            bbop_pkg::OP_BCLR: begin
                o_result = i_opnd & ~bbop_pkg::bit_mask(i_bit);
                o_write = 1'b1;
            end
            bbop_pkg::OP_BTSZ: begin
                o_skip = ~|(i_opnd & bbop_pkg::bit_mask(i_bit));
            end
            default: begin
                o_result = i_opnd;
            end
        endcase
        o_zero = bbop_pkg::is_zero(o_result);
    end
endmodule

// >>> hw/byte_bit_op_execute_unit.sv
// Execute unit for accumulator and file register byte and bit operations
module byte_bit_op_execute_unit (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_valid,
    input wire bbop_pkg::op_t i_op,
    input wire logic [6:0] i_addr,
    input wire logic i_dest,
    input wire logic [2:0] i_bit,
    input wire logic [15:0] i_ptr0,
    input wire logic [15:0] i_ptr1,
    input wire logic i_load_en,
    input wire logic [6:0] i_load_addr,
    input wire logic [7:0] i_load_data,
    input wire logic i_acc_load_en,
    input wire logic [7:0] i_acc_load_data,
    input wire logic [6:0] i_peek_addr,
    output logic o_ready,
    output logic o_done,
    output logic o_squashed,
    output logic o_skip_taken,
    output logic [7:0] o_acc,
    output logic o_carry,
    output logic o_nibble,
    output logic o_zero,
    output logic [7:0] o_peek_data
);
    typedef enum logic {
        ST_IDLE,
        ST_STALL
    } state_t;

    state_t state;
    logic [7:0] acc;
    logic carry;
    logic nibble;
    logic zero;
    logic [7:0] regs [bbop_pkg::NUM_REGS];
    logic skip_pending;

    // Instruction held over the extra indirect cycle
    bbop_pkg::op_t held_op;
    logic [6:0] held_index;
    logic held_dest;
    logic [2:0] held_bit;

    // Current instruction view, either fresh from the port or held
    bbop_pkg::op_t cur_op;
    logic [6:0] cur_index;
    logic cur_dest;
    logic [2:0] cur_bit;
    logic [6:0] in_index;
    logic in_slow;
    logic accept;
    logic exec;
    logic commit;

    logic [7:0] alu_result;
    logic alu_carry;
    logic alu_nibble;
    logic alu_zero;
    logic upd_carry;
    logic upd_nibble;
    logic upd_zero;
    logic alu_write;
    logic alu_skip;

    // Indirect ports resolve through the low bits of their pointer pair
    always_comb begin
        in_index = i_addr;
        in_slow = 1'b0;
        if (i_addr == bbop_pkg::IND0_ADDR) begin
            in_index = i_ptr0[6:0];
            in_slow = i_ptr0[bbop_pkg::PTR_MSB_POS];
        end else if (i_addr == bbop_pkg::IND1_ADDR) begin
            in_index = i_ptr1[6:0];
            in_slow = i_ptr1[bbop_pkg::PTR_MSB_POS];
        end
        // A discarded instruction never pays the extra cycle
        if (skip_pending || i_op == bbop_pkg::OP_NOP) begin
            in_slow = 1'b0;
        end
    end

    // Accept only while idle; a slow access executes one cycle later
    assign o_ready = (state == ST_IDLE);
    assign accept = o_ready && i_valid;
    assign exec = (accept && !in_slow) || (state == ST_STALL);
    assign commit = exec && !skip_pending;

    always_comb begin
        if (state == ST_STALL) begin
            cur_op = held_op;
            cur_index = held_index;
            cur_dest = held_dest;
            cur_bit = held_bit;
        end else begin
            cur_op = i_op;
            cur_index = in_index;
            cur_dest = i_dest;
            cur_bit = i_bit;
        end
    end

    bbop_alu u_alu (
        .i_op(cur_op),
        .i_acc(acc),
        .i_opnd(regs[cur_index]),
        .i_carry(carry),
        .i_bit(cur_bit),
        .o_result(alu_result),
        .o_carry(alu_carry),
        .o_nibble(alu_nibble),
        .o_zero(alu_zero),
        .o_upd_carry(upd_carry),
        .o_upd_nibble(upd_nibble),
        .o_upd_zero(upd_zero),
        .o_write(alu_write),
        .o_skip(alu_skip)
    );

    // Sequencing: one stall cycle for a slow indirect access
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= ST_IDLE;
        end else if (accept && in_slow) begin
            state <= ST_STALL;
        end else begin
            state <= ST_IDLE;
        end
    end

    // Capture the instruction for the stalled execute cycle
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            held_op <= bbop_pkg::OP_NOP;
            held_index <= 7'h00;
            held_dest <= bbop_pkg::DEST_ACC;
            held_bit <= 3'h0;
        end else if (accept) begin
            held_op <= i_op;
            held_index <= in_index;
            held_dest <= i_dest;
            held_bit <= i_bit;
        end
    end

    // A taken skip turns the next executed instruction into a no-op cycle
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            skip_pending <= 1'b0;
        end else if (exec) begin
            skip_pending <= commit && alu_skip;
        end
    end

    // Accumulator: target 0, or a direct load from the surrounding core
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            acc <= bbop_pkg::ACC_RST;
        end else if (commit && alu_write && cur_op != bbop_pkg::OP_BCLR
                     && cur_dest == bbop_pkg::DEST_ACC) begin
            acc <= alu_result;
        end else if (i_acc_load_en) begin
            acc <= i_acc_load_data;
        end
    end

    // Register file; bit clear always writes back into its register
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < bbop_pkg::NUM_REGS; i++) begin
                regs[i] <= bbop_pkg::REG_RST;
            end
        end else if (commit && alu_write && (cur_op == bbop_pkg::OP_BCLR
                     || cur_dest == bbop_pkg::DEST_REG)) begin
            regs[cur_index] <= alu_result;
        end else if (i_load_en) begin
            regs[i_load_addr] <= i_load_data;
        end
    end

    // Status flags move only for operations that own them
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            carry <= bbop_pkg::FLAG_RST;
            nibble <= bbop_pkg::FLAG_RST;
            zero <= bbop_pkg::FLAG_RST;
        end else if (commit) begin
            if (upd_carry) begin
                carry <= alu_carry;
            end
            if (upd_nibble) begin
                nibble <= alu_nibble;
            end
            if (upd_zero) begin
                zero <= alu_zero;
            end
        end
    end

    // Completion pulses, one per executed or discarded instruction
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_done <= 1'b0;
            o_squashed <= 1'b0;
            o_skip_taken <= 1'b0;
        end else begin
            o_done <= exec;
            o_squashed <= exec && skip_pending;
            o_skip_taken <= commit && alu_skip;
        end
    end

    // Peek port lets the core read back any register a cycle later
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_peek_data <= bbop_pkg::REG_RST;
        end else begin
            o_peek_data <= regs[i_peek_addr];
        end
    end

    assign o_acc = acc;
    assign o_carry = carry;
    assign o_nibble = nibble;
    assign o_zero = zero;
endmodule

// >>> bench/bbop_chk.sv
// Port-level timing and flag checks for the execute unit
module bbop_chk (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_valid,
    input wire bbop_pkg::op_t i_op,
    input wire logic o_ready,
    input wire logic o_done,
    input wire logic o_squashed,
    input wire logic o_skip_taken,
    input wire logic o_carry,
    input wire logic o_nibble,
    input wire logic o_zero
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    // A taken request completes after one cycle, or two when it stalls
    take_done_a: assert property (i_valid && o_ready |=> (o_done or (!o_ready ##1 o_done)))
        else $error("completion missing after take");
    // The extra indirect cycle is exactly one cycle long
    stall_short_a: assert property (!o_ready |=> o_ready)
        else $error("stall longer than one cycle");
    skip_pulse_a: assert property (o_skip_taken |-> o_done && !o_squashed)
        else $error("skip pulse without completion");
    skip_hold_a: assert property (o_skip_taken |-> $stable({o_carry, o_nibble, o_zero}))
        else $error("bit test changed a flag");
    squash_hold_a: assert property (o_squashed |-> o_done && $stable({o_carry, o_nibble, o_zero}))
        else $error("discarded slot changed a flag");
    // Flags move only on a commit, so never outside a completion cycle
    flags_idle_a: assert property (!o_done |-> $stable({o_carry, o_nibble, o_zero}))
        else $error("flags changed without completion");
    and_flags_a: assert property (i_valid && o_ready && i_op == bbop_pkg::OP_AND ##1 o_done && o_ready
        |-> $stable({o_carry, o_nibble}))
        else $error("and touched carry or nibble");
    bclr_flags_a: assert property (i_valid && o_ready && i_op == bbop_pkg::OP_BCLR ##1 o_done && o_ready
        |-> $stable({o_carry, o_nibble, o_zero}))
        else $error("bit clear touched a flag");
endmodule

bind byte_bit_op_execute_unit bbop_chk chk (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_valid(i_valid), .i_op(i_op),
    .o_ready(o_ready), .o_done(o_done), .o_squashed(o_squashed), .o_skip_taken(o_skip_taken),
    .o_carry(o_carry), .o_nibble(o_nibble), .o_zero(o_zero));

// >>> bench/byte_bit_op_execute_unit_test.sv
// Self-checking bench for the execute unit with a reference model
module byte_bit_op_execute_unit_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_mclk = 0, i_rstn = 0, i_valid = 0, i_dest = 0, i_load_en = 0, i_acc_load_en = 0;
    bbop_pkg::op_t i_op = bbop_pkg::OP_NOP;
    logic [6:0] i_addr = '0, i_load_addr = '0, i_peek_addr = '0;
    logic [2:0] i_bit = '0;
    logic [15:0] i_ptr0 = '0, i_ptr1 = '0;
    logic [7:0] i_load_data = '0, i_acc_load_data = '0;
    logic o_ready, o_done, o_squashed, o_skip_taken, o_carry, o_nibble, o_zero;
    logic [7:0] o_acc, o_peek_data;
    int n_mismatch = 0, checked = 0;
    logic [31:0] seed = 32'h9b25_85af;
    logic [7:0] regs [128];
    logic [7:0] acc = '0;
    logic c = 0, nf = 0, z = 0, skip = 0;
    logic [12:0] expq [$];

    byte_bit_op_execute_unit uut (.i_mclk, .i_rstn, .i_valid, .i_op, .i_addr, .i_dest, .i_bit, .i_ptr0, .i_ptr1,
        .i_load_en, .i_load_addr, .i_load_data, .i_acc_load_en, .i_acc_load_data, .i_peek_addr, .o_ready,
        .o_done, .o_squashed, .o_skip_taken, .o_acc, .o_carry, .o_nibble, .o_zero, .o_peek_data);

    always #4 i_mclk = ~i_mclk;

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic check(input string what, input logic [12:0] exp, input logic [12:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic idle(input int n);
        i_valid <= 0;
        repeat (n) @(posedge i_mclk);
    endtask

    // Model one instruction, then hold it on the port until taken
    task automatic issue(input bbop_pkg::op_t op, input logic [6:0] a, input logic d, input logic [2:0] b);
        logic [7:0] f, r;
        logic [8:0] s;
        logic [4:0] nib;
        logic [6:0] ea;
        logic slow, sq, sk, cin, rdy;
        ea = (a < 2) ? (a[0] ? i_ptr1[6:0] : i_ptr0[6:0]) : a;
        slow = a < 2 && (a[0] ? i_ptr1[15] : i_ptr0[15]) && op != bbop_pkg::OP_NOP && !skip;
        f = regs[ea];
        sq = skip;
        sk = 0;
        skip = 0;
        cin = op == bbop_pkg::OP_ADDC && c;
        s = acc + f + cin;
        nib = acc[3:0] + f[3:0] + cin;
        // A discarded slot writes nothing and keeps every flag
        if (!sq) begin
            case (op)
                bbop_pkg::OP_AND: r = acc & f;
                bbop_pkg::OP_ASR: r = {f[7], f[7:1]};
                bbop_pkg::OP_BCLR: r = f & ~(8'h01 << b);
                default: r = s[7:0];
            endcase
            if (op inside {bbop_pkg::OP_ADD, bbop_pkg::OP_ADDC}) {c, nf} = {s[8], nib[4]};
            if (op == bbop_pkg::OP_ASR) c = f[0];
            if (op inside {bbop_pkg::OP_AND, bbop_pkg::OP_ADD, bbop_pkg::OP_ASR, bbop_pkg::OP_ADDC}) begin
                z = r == 8'h00;
                if (d) regs[ea] = r;
                else acc = r;
            end
            if (op == bbop_pkg::OP_BCLR) regs[ea] = r;
            if (op == bbop_pkg::OP_BTSZ) sk = !f[b];
            skip = sk;
        end
        expq.push_back({acc, c, nf, z, sq, sk});
        i_valid <= 1;
        i_op <= op;
        i_addr <= a;
        i_dest <= d;
        i_bit <= b;
        rdy = 0;
        for (int k = 0; k < 8 && !rdy; k++) begin
            @(negedge i_mclk) rdy = o_ready === 1'b1;
            @(posedge i_mclk);
        end
        if (!rdy) check("take", 13'h0001, 13'h0000);
        // Hold the pointers steady while a slow access finishes
        if (slow) idle(2);
    endtask

    // Every completion is compared with the oldest prediction
    always @(negedge i_mclk) begin
        if (o_done === 1'b1) begin
            if (expq.size() == 0) check("extra done", 13'h0000, 13'h1fff);
            else check("state", expq.pop_front(),
                {o_acc, o_carry, o_nibble, o_zero, o_squashed, o_skip_taken});
        end
    end

    initial begin
        repeat (100000) @(posedge i_mclk);
        check("timeout", 13'h0000, 13'h0001);
        close_out();
    end

    initial begin
        for (int i = 0; i < 128; i++) regs[i] = 8'h00;
        repeat (3) @(posedge i_mclk);
        i_rstn <= 1;
        // Preload registers and accumulator through the direct load ports
        for (int i = 2; i < 128; i++) begin
            seed = lfsr(seed);
            i_load_en <= 1;
            i_load_addr <= 7'(i);
            i_load_data <= seed[7:0];
            regs[i] = seed[7:0];
            @(posedge i_mclk);
        end
        i_load_en <= 0;
        i_acc_load_en <= 1;
        i_acc_load_data <= seed[15:8];
        acc = seed[15:8];
        @(posedge i_mclk);
        i_acc_load_en <= 0;
        // Random back-to-back instructions, pointers never aim at the ports
        for (int n = 0; n < 600; n++) begin
            seed = lfsr(seed);
            if (n % 32 == 0) begin
                idle(1);
                i_ptr0 <= {seed[31:23], seed[22:16] | 7'h02};
                i_ptr1 <= {seed[15:7], seed[6:0] | 7'h02};
                idle(1);
            end
            issue(bbop_pkg::op_t'(seed[2:0] % 3'd7), seed[5:3] == 0 ? {6'h00, seed[6]} : seed[13:7], seed[14],
                seed[17:15]);
        end
        idle(4);
        check("pending", 13'h0000, 13'(expq.size()));
        // Sweep register contents through the readback port
        for (int i = 2; i < 128; i++) begin
            @(posedge i_mclk) i_peek_addr <= 7'(i);
            @(posedge i_mclk);
            @(negedge i_mclk);
            check("register", {5'h00, regs[i]}, {5'h00, o_peek_data});
        end
        close_out();
    end
endmodule
